// ===== verilog/ifeb_map.svh
// Behaviour
// - flags read 1 after request, software writable
// - enable bit passes or blocks its request
// - flags0 bits 2,1,0: compare1, capture1, ext0
// - flags1 layout fixed; bits 12, 10-7 zero
// - flags2: pairs 5-0 at 10-5, comparator4 bit0
// - enables0 upper byte layout; bit 15 zero
// - enables0 lower byte layout; bit 4 zero
// - all bits reset zero; unimplemented read zero
`ifndef IFEB_MAP_SVH
`define IFEB_MAP_SVH
// register byte addresses
`define IFEB_OFF_FLAGS0   6'h00
`define IFEB_OFF_FLAGS1   6'h04
`define IFEB_OFF_FLAGS2   6'h08
`define IFEB_OFF_ENABLES0 6'h0c
`define IFEB_OFF_ENABLES1 6'h10
`define IFEB_OFF_ENABLES2 6'h14
`define IFEB_OFF_IRQ_STAT 6'h18
`define IFEB_OFF_IRQ_EN   6'h1c
`define IFEB_OFF_IRQ_CLR  6'h20
// implemented bit masks
`define IFEB_MASK_FLAGS0  16'h7fef
`define IFEB_MASK_FLAGS1  16'he87f
`define IFEB_MASK_FLAGS2  16'h07e1
// reset values
`define IFEB_RST_REG      16'h0000
`define IFEB_RST_IRQ      3'h0
// interrupt status bit positions
`define IFEB_EV_REQ       0
`define IFEB_EV_SWSET     1
`define IFEB_EV_BADADDR   2
`endif

// ===== verilog/ifeb_pkg.sv
`default_nettype none
package ifeb_pkg;
    // one 16-bit bank register
    typedef logic [15:0] ifeb_word_t;
    // bus answer state
    typedef enum logic [1:0]
    {
        IFEB_IDLE = 2'b00,
        IFEB_RESP = 2'b01,
        IFEB_DONE = 2'b10
    } ifeb_bus_state_t;
endpackage : ifeb_pkg
`default_nettype wire

// ===== verilog/ifeb_reg_bank.sv
`default_nettype none
`include "ifeb_map.svh"
// one flag register and its enable register, three copies made in the top
module ifeb_reg_bank
#(
    parameter logic [15:0] MASK = 16'hffff
)
(
    // clock and reset
    input  wire logic            clk_i,
    input  wire logic            rstn_i,
    // source pulses
    input  wire logic [15:0]     src_i,
    // software access
    input  wire logic            wr_flag_i,
    input  wire logic            wr_en_i,
    input  wire logic [15:0]     wdata_i,
    // state out
    output logic      [15:0]     flags_o,
    output logic      [15:0]     enables_o,
    output logic      [15:0]     gated_o
);
    import ifeb_pkg::*;
    typedef struct packed
    {
        ifeb_word_t flags;   // sticky request flags
        ifeb_word_t enables; // per-source enables
    } ifeb_bank_t;
    ifeb_bank_t st;
    ifeb_bank_t next_st;
    // next state: a source pulse wins over a software write of zero
    always_comb
    begin
        next_st = st;
        if (wr_flag_i)
        begin
            next_st.flags = wdata_i;
        end
        next_st.flags   = (next_st.flags | src_i) & MASK;
        if (wr_en_i)
        begin
            next_st.enables = wdata_i & MASK;
        end
    end
    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            st <= {`IFEB_RST_REG, `IFEB_RST_REG};
        end
        else
        begin
            st <= next_st;
        end
    end
    assign flags_o   = st.flags;
    assign enables_o = st.enables;
    assign gated_o   = st.flags & st.enables;
endmodule : ifeb_reg_bank
`default_nettype wire

// ===== verilog/ifeb_bus_slave.sv
`default_nettype none
// avalon-mm handshake: two wait cycles, then an acknowledge cycle
module ifeb_bus_slave
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // bus request
    input  wire logic read_i,
    input  wire logic write_i,
    // access accepted this cycle
    output logic      accept_o,
    output logic      waitrequest_o
);
    import ifeb_pkg::*;
    typedef struct packed
    {
        ifeb_bus_state_t state; // handshake phase
        logic            wait_n; // registered inverted waitrequest, high means done
    } ifeb_bus_t;
    ifeb_bus_t st;
    ifeb_bus_t next_st;
    // waitrequest high by default; it drops only in the done cycle, once read data is registered
    always_comb
    begin
        next_st = st;
        next_st.wait_n = 1'b0;
        case (st.state)
            IFEB_IDLE:
            begin
                if (read_i || write_i)
                begin
                    next_st.state = IFEB_RESP;
                end
            end
            IFEB_RESP:
            begin
                next_st.state  = IFEB_DONE;
                next_st.wait_n = 1'b1;
            end
            default:
            begin
                next_st.state = IFEB_IDLE;
            end
        endcase
    end
    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            st <= {IFEB_IDLE, 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end
    assign accept_o      = (st.state == IFEB_RESP);
    assign waitrequest_o = ~st.wait_n;
endmodule : ifeb_bus_slave
`default_nettype wire

// ===== verilog/ifeb_top.sv
// Design decisions made here: the Avalon-MM register port and the address map.
`default_nettype none
`include "ifeb_map.svh"
// interrupt flag and enable bank with an avalon-mm register port
module ifeb_top
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // avalon-mm slave
    input  wire logic [5:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic      [1:0]  response_o,
    output logic             waitrequest_o,
    // request pulses from sources, one word per flag register
    input  wire logic [15:0] src0_i,
    input  wire logic [15:0] src1_i,
    input  wire logic [15:0] src2_i,
    // gated requests toward priority logic
    output logic      [15:0] req0_o,
    output logic      [15:0] req1_o,
    output logic      [15:0] req2_o,
    output logic             any_req_o,
    // block interrupt
    output logic             irq_o
);
    import ifeb_pkg::*;
    localparam logic [15:0] MASKS [3] = '{`IFEB_MASK_FLAGS0, `IFEB_MASK_FLAGS1, `IFEB_MASK_FLAGS2};
    // address decode helper
    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        hit = (a == off);
    endfunction : hit
    typedef struct packed
    {
        logic [31:0] rdata;   // registered read data
        logic [1:0]  resp;    // registered response
        logic [47:0] req;     // registered gated requests
        logic        any;     // any request pending
        logic [2:0]  istat;   // sticky block events
        logic [2:0]  ien;     // block event enables
        logic        irq;     // registered interrupt
        logic        acc_d;   // accept one cycle late: write commit cycle
    } ifeb_top_t;
    ifeb_top_t st;
    ifeb_top_t next_st;
    logic        accept;     // bus access accepted; answer registers next edge, a write commits one edge later
    logic        bus_wait;   // from handshake
    logic [47:0] flags;      // flag words
    logic [47:0] enables;    // enable words
    logic [47:0] gated;      // flag and enable
    logic [47:0] srcs;       // all sources
    logic        wr_lo;      // both low byte lanes write
    logic [2:0]  wr_flag;    // flag register write
    logic [2:0]  wr_en;      // enable register write
    logic [2:0]  ev;         // block events this cycle
    logic        mapped;     // address decodes
    assign srcs  = {src2_i, src1_i, src0_i};
    // partial word writes go through only with both low lanes, keeping 16-bit registers whole
    // writes commit in the cycle waitrequest is low, so they land on the master's sampling edge
    assign wr_lo = st.acc_d && write_i && (byteenable_i[1:0] == 2'b11);
    // handshake engine
    ifeb_bus_slave u_bus
    (
        .clk_i         (clk_i),
        .rstn_i        (rstn_i),
        .read_i        (read_i),
        .write_i       (write_i),
        .accept_o      (accept),
        .waitrequest_o (bus_wait)
    );
    // three flag/enable banks
    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_bank
            assign wr_flag[g] = wr_lo && hit(address_i, 6'(4 * g));
            assign wr_en[g]   = wr_lo && hit(address_i, 6'(`IFEB_OFF_ENABLES0 + 4 * g));
            ifeb_reg_bank
            #(
                .MASK (MASKS[g])
            )
            u_bank
            (
                .clk_i     (clk_i),
                .rstn_i    (rstn_i),
                .src_i     (srcs[16*g +: 16]),
                .wr_flag_i (wr_flag[g]),
                .wr_en_i   (wr_en[g]),
                .wdata_i   (writedata_i[15:0]),
                .flags_o   (flags[16*g +: 16]),
                .enables_o (enables[16*g +: 16]),
                .gated_o   (gated[16*g +: 16])
            );
        end
    endgenerate
    // enables0 shares flags0 layout: bit 15 and bit 4 stay zero
    assign mapped = (address_i <= `IFEB_OFF_IRQ_CLR) && (address_i[1:0] == 2'b00);
    // block events: a new gated request, software setting a flag, a bad address
    assign ev[`IFEB_EV_REQ]     = |(gated & ~st.req);
    assign ev[`IFEB_EV_SWSET]   = |(wr_flag & {|writedata_i[15:0], |writedata_i[15:0], |writedata_i[15:0]});
    assign ev[`IFEB_EV_BADADDR] = accept && !mapped;
    // read mux, status update and outputs
    always_comb
    begin
        next_st       = st;
        next_st.req   = gated;
        next_st.any   = |gated;
        next_st.acc_d = accept;
        if (accept)
        begin
            next_st.resp  = mapped ? 2'b00 : 2'b11;
            next_st.rdata = 32'h0000_0000;
            case (address_i)
                `IFEB_OFF_FLAGS0:   next_st.rdata[15:0] = flags[15:0];
                `IFEB_OFF_FLAGS1:   next_st.rdata[15:0] = flags[31:16];
                `IFEB_OFF_FLAGS2:   next_st.rdata[15:0] = flags[47:32];
                `IFEB_OFF_ENABLES0: next_st.rdata[15:0] = enables[15:0];
                `IFEB_OFF_ENABLES1: next_st.rdata[15:0] = enables[31:16];
                `IFEB_OFF_ENABLES2: next_st.rdata[15:0] = enables[47:32];
                `IFEB_OFF_IRQ_STAT: next_st.rdata[2:0]  = st.istat;
                `IFEB_OFF_IRQ_EN:   next_st.rdata[2:0]  = st.ien;
                default:            next_st.rdata       = 32'h0000_0000;      // clear reg is write-only
            endcase
        end
        // clear first, then set, so an event in the clearing cycle survives
        if (wr_lo && hit(address_i, `IFEB_OFF_IRQ_CLR))
        begin
            next_st.istat = st.istat & ~writedata_i[2:0];
        end
        next_st.istat = next_st.istat | ev;
        if (wr_lo && hit(address_i, `IFEB_OFF_IRQ_EN))
        begin
            next_st.ien = writedata_i[2:0];
        end
        next_st.irq = |(next_st.istat & next_st.ien);
    end
    // state register
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
    // outputs straight from flip-flops
    assign readdata_o    = st.rdata;
    assign response_o    = st.resp;
    assign waitrequest_o = bus_wait;
    assign req0_o        = st.req[15:0];
    assign req1_o        = st.req[31:16];
    assign req2_o        = st.req[47:32];
    assign any_req_o     = st.any;
    assign irq_o         = st.irq;
endmodule : ifeb_top
`default_nettype wire

// ===== dv/ifeb_checker.sv
`default_nettype none
// watches the register port and the gated request outputs
module ifeb_checker
(
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // register port
    input wire logic [5:0]  address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] readdata_o,
    input wire logic [1:0]  response_o,
    input wire logic        waitrequest_o,
    // requests out
    input wire logic [15:0] req0_o,
    input wire logic [15:0] req1_o,
    input wire logic [15:0] req2_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    // a request leaves idle
    sequence req_start;
        $rose(read_i || write_i);
    endsequence
    // two wait edges, then the answer
    sequence two_wait_answer;
        waitrequest_o [*2] ##1 !waitrequest_o;
    endsequence
    a_wait_two: assert property (disable iff (!rstn_i) req_start |-> two_wait_answer)
        else $error("answer not on the third edge");
    a_wait_idle: assert property (disable iff (!rstn_i) !(read_i || write_i) |-> waitrequest_o)
        else $error("waitrequest low while idle");
    a_unmapped_zero: assert property (disable iff (!rstn_i)
        read_i && !waitrequest_o && address_i > 6'h20 |-> response_o == 2'b11 && readdata_o == 32'h0)
        else $error("unmapped read not refused");
    a_upper_zero: assert property (disable iff (!rstn_i) read_i && !waitrequest_o |-> readdata_o[31:16] == 16'h0)
        else $error("upper read half not zero");
    a_req0_mask: assert property (disable iff (!rstn_i) (req0_o & ~16'h7fef) == 16'h0)
        else $error("request on bit 15 or 4 of bank 0");
    a_req1_mask: assert property (disable iff (!rstn_i) (req1_o & ~16'he87f) == 16'h0)
        else $error("request on empty bit of bank 1");
    a_req2_mask: assert property (disable iff (!rstn_i) (req2_o & ~16'h07e1) == 16'h0)
        else $error("request on empty bit of bank 2");
    // no disable here: it checks the reset itself
    a_reset_quiet: assert property (!rstn_i |=> waitrequest_o && !irq_o && response_o == 2'b00
        && req0_o == 16'h0 && req1_o == 16'h0 && req2_o == 16'h0)
        else $error("outputs not cleared by reset");
    // without a write two edges back no req0_o request may drop
    a_req_sticky: assert property (disable iff (!rstn_i) !$past(write_i, 2) |-> ($past(req0_o) & ~req0_o) == 16'h0)
        else $error("request dropped without a write");
endmodule : ifeb_checker
bind ifeb_top ifeb_checker u_ifeb_checker (.clk_i(clk_i), .rstn_i(rstn_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .readdata_o(readdata_o), .response_o(response_o),
    .waitrequest_o(waitrequest_o), .req0_o(req0_o), .req1_o(req1_o), .req2_o(req2_o), .irq_o(irq_o));
`default_nettype wire

// ===== dv/ifeb_src_model.sv
`default_nettype none
// request sources: one-cycle pulses, then back to quiet
module ifeb_src_model
(
    // clock and command
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [47:0] word_i,
    // pulses toward the bank
    output logic      [15:0] src0_o,
    output logic      [15:0] src1_o,
    output logic      [15:0] src2_o
);
    // a source raises its request for each cycle that go_i is high
    always_ff @(posedge clk_i)
    begin
        {src2_o, src1_o, src0_o} <= go_i ? word_i : 48'h0;
    end
endmodule : ifeb_src_model
`default_nettype wire

// ===== dv/tb_irq_flag_enable_bank.sv
`default_nettype none
module tb_irq_flag_enable_bank;
    timeunit 1ns;
    timeprecision 1ps;
    `define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
        $display("unexpected at %0t: got %h want %h", $time, g, e); end end
    logic        clk_i = 0, rstn_i = 0, read_i = 0, write_i = 0, go = 0;
    logic [5:0]  address_i = 0;
    logic [31:0] writedata_i = 0, readdata_o, seed = 32'h88a1239b;
    logic [3:0]  byteenable_i = 4'hf;
    logic [1:0]  response_o;
    logic [15:0] src0, src1, src2, req0_o, req1_o, req2_o;
    logic [47:0] word = 0, en = 0;
    logic [33:0] expq [$], exp_v;
    logic        waitrequest_o, any_req_o, irq_o;
    int          n_mismatch = 0, checks = 0;
    // implemented bits: flags 0..2, then enables 0..2
    logic [15:0] mask [6] = '{16'h7fef, 16'he87f, 16'h07e1, 16'h7fef, 16'he87f, 16'h07e1};
    initial forever #2.5 clk_i = ~clk_i;
    ifeb_top u_ifeb_top (.clk_i, .rstn_i, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
        .readdata_o, .response_o, .waitrequest_o, .src0_i(src0), .src1_i(src1), .src2_i(src2),
        .req0_o, .req1_o, .req2_o, .any_req_o, .irq_o);
    ifeb_src_model u_ifeb_src_model (.clk_i, .go_i(go), .word_i(word), .src0_o(src0), .src1_o(src1), .src2_o(src2));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    // one bus cycle; a read notes its expected answer first
    task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d, input logic [1:0] r = 2'b00);
        int n;
        if (!wr)
            expq.push_back({r, 16'h0, d});
        repeat (2) @(posedge clk_i);
        address_i <= a;
        read_i <= !wr;
        write_i <= wr;
        writedata_i <= {seed[31:16], d};
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (waitrequest_o !== 1'b0 && n < 20);
        if (n >= 20)
        begin
            n_mismatch++;
            stop_test();
        end
        read_i <= 1'b0;
        write_i <= 1'b0;
    endtask : bus
    // answer watcher takes the oldest note
    always @(posedge clk_i)
    begin
        if (read_i && waitrequest_o === 1'b0 && expq.size() > 0)
        begin
            exp_v = expq.pop_front();
            `CHK({response_o, readdata_o}, exp_v)
        end
    end
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // far longer than the sequence needs
    initial
    begin
        #200us;
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 8; i++)
            bus(0, 6'(i * 4), 16'h0);
        // all ones read back as the implemented bits only
        for (int i = 0; i < 6; i++)
        begin
            bus(1, 6'(i * 4), 16'hffff);
            bus(0, 6'(i * 4), mask[i]);
        end
        repeat (2) @(posedge clk_i);
        `CHK({req2_o, req1_o, req0_o}, {mask[2], mask[1], mask[0]})
        bus(1, 6'h0c, 16'h0);
        repeat (3) @(posedge clk_i);
        `CHK(req0_o, 16'h0)
        // random pulses under random enables; flags must hold
        for (int k = 0; k < 8; k++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                bus(1, 6'(i * 4), 16'h0);
                seed = xs(seed);
                en[i * 16 +: 16] = seed[15:0];
                bus(1, 6'(i * 4 + 12), seed[15:0]);
            end
            seed = xs(seed);
            @(posedge clk_i);
            word <= {seed[15:0], seed[31:16], seed[23:8]};
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
            repeat (4) @(posedge clk_i);
            `CHK({req2_o, req1_o, req0_o}, word & en & {mask[2], mask[1], mask[0]})
            `CHK(any_req_o, |(word & en & {mask[2], mask[1], mask[0]}))
            repeat (10) @(posedge clk_i);
            for (int i = 0; i < 3; i++)
                bus(0, 6'(i * 4), word[i * 16 +: 16] & mask[i]);
        end
        // a write without both low byte lanes is ignored
        byteenable_i <= 4'h1;
        bus(1, 6'h0c, 16'hffff);
        byteenable_i <= 4'hf;
        bus(0, 6'h0c, en[15:0] & mask[0]);
        for (int i = 0; i < 3; i++)
        begin
            bus(1, 6'(i * 4), 16'h0);
            bus(0, 6'(i * 4), 16'h0);
        end
        `CHK(any_req_o, 1'b0)
        // unmapped access raises the interrupt, mask and clear drop it
        bus(1, 6'h20, 16'h0007);
        bus(1, 6'h1c, 16'h0004);
        bus(0, 6'h30, 16'h0, 2'b11);
        bus(0, 6'h18, 16'h0004);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        bus(1, 6'h1c, 16'h0);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        bus(1, 6'h1c, 16'h0004);
        bus(1, 6'h20, 16'h0004);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        // second reset in mid-run
        rstn_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        bus(0, 6'h1c, 16'h0);
        stop_test();
    end
endmodule : tb_irq_flag_enable_bank
`default_nettype wire
